// ===== verilog/pin_mux_pkg.sv
package pin_mux_pkg;
  // function codes of the pin-owner enum, one-hot
  localparam int FUNC_W = 8;
  localparam logic [7:0] OWN_GPIO = 8'h01;
  localparam logic [7:0] OWN_PERIPH_OUT = 8'h02;
  localparam logic [7:0] OWN_PERIPH_IN = 8'h04;
  localparam logic [7:0] OWN_PERIPH_IN_PU = 8'h08;
  localparam logic [7:0] OWN_ANALOG = 8'h10;
  localparam logic [7:0] OWN_DISPLAY = 8'h20;
  localparam logic [7:0] OWN_OPTION = 8'h40;
  // port0 drive-mode value that makes bits 4 and 5 open drain
  localparam logic [7:0] P0_OPEN_DRAIN_BOTH = 8'h30;
  localparam int P0_OD_LO = 4;
  localparam int P0_OD_HI = 5;
  // timer-3 clock-select value for external input
  localparam logic [1:0] TMR3_EXT_CLK = 2'h1;
  // reset value of the latched uart0 transmit ownership
  localparam logic TX0_OWN_RESET = 1'b0;
  typedef enum logic [7:0] {
    O_GPIO = 8'h01,
    O_OUT = 8'h02,
    O_IN = 8'h04,
    O_IN_PU = 8'h08,
    O_ANALOG = 8'h10,
    O_DISP = 8'h20,
    O_OPT = 8'h40
  } owner_t;
endpackage

// ===== verilog/pad_cell_ctrl.sv
`timescale 1ns/1ps
module pad_cell_ctrl
  import pin_mux_pkg::*;
(
  // ownership
  input wire owner_t owner,
  input wire logic alt_out,
  input wire logic open_drain,
  // gpio registers
  input wire logic gpio_dir,
  input wire logic gpio_pull,
  input wire logic gpio_data,
  // pad
  output logic pad_oe,
  output logic pad_do,
  output logic pad_pu,
  output logic pad_analog
);
  always_comb begin
    pad_oe = 1'b0;
    pad_do = 1'b0;
    pad_pu = 1'b0;
    pad_analog = 1'b0;
    case (owner)
      O_GPIO: begin
        // data register only reaches the pad while gpio owns it
        pad_oe = gpio_dir & (~open_drain | ~gpio_data);
        pad_do = gpio_data;
        pad_pu = ~gpio_dir & gpio_pull;
      end
      O_OUT: begin
        pad_oe = ~open_drain | ~alt_out;
        pad_do = alt_out;
      end
      O_IN_PU: pad_pu = 1'b1;
      O_ANALOG: pad_analog = 1'b1;
      O_DISP: begin
        pad_oe = 1'b1;
        pad_do = alt_out;
      end
      O_IN, O_OPT: pad_pu = 1'b0;
      default: pad_pu = 1'b0;
    endcase
  end
endmodule

// ===== verilog/port_function_priority_mux.sv
`timescale 1ns/1ps
// How it works
// - with no alternate function enabled, a pin is plain gpio.
// - p0.0 is complementary channel-b pwm when unit one and chan b enabled.
// - p0.0-2 become lcd segments 17-19 when lcd chosen and select set.
// - p0.1 is pwm zero channel-b when unit zero and chan b enabled.
// - p0.2/p0.3 are channel-a pwm outputs when unit zero and chan a enabled.
// - p0.3 is timer-4 input with pull-up when run and ext clock set.
// - p0.4 is timer-2 capture/reload input with pull-up per mode conditions.
// - p0.4 feeds irq 0 when enabled and pin is input.
// - p0.5 is timer-2 counter input with pull-up or clock output.
// - p0.5-7 feed irq 1-3 when enabled and pin is input.
// - p0.4/p0.5 drive open drain when drive mode register holds 30h.
// - p1.0-3 feed group irqs when group enable, select, and input.
// - port1 bits are led segments, else lcd segments, when selected.
// - p2.0 is uart0 receive with pull-up when receive enabled.
// - p2.1 becomes uart0 transmit after a write to its buffer.
// - p2.2 is spi slave data in, else uart1 receive with pull-up.
// - p2.5 is pwm fault input when enabled, over slave select.
// - p2.5 is spi slave select with pull-up under master/slave conditions.
// - p3.4-7 go analog when channel, converter-on and select field set.
// - port3 bits become led or lcd commons when select and duty set.
// - p4.4 is reference input, else analog channel 8.
// - p5.3 is buzzer output, else timer-3 input with pull-up.
// - a higher-priority function keeps the pin against lower ones.
// - port data writes never reach a pad owned by a function.
module port_function_priority_mux
  import pin_mux_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // gpio registers, 48 bits (6 ports x 8)
  input wire logic [47:0] gpio_dir,
  input wire logic [47:0] gpio_pull,
  input wire logic [47:0] gpio_data,
  // pwm
  input wire logic pwm_unit_zero_en,
  input wire logic pwm_unit_one_en,
  input wire logic chan_a_out_en,
  input wire logic chan_b_out_en,
  input wire logic pwm_comp_chan_b_out,
  input wire logic pwm_zero_chan_b_out,
  input wire logic pwm_comp_chan_a_out,
  input wire logic pwm_zero_chan_a_out,
  input wire logic fault_in_en,
  // display
  input wire logic led_not_lcd_sel,
  input wire logic display_duty,
  input wire logic [2:0] p0_seg_sel,
  input wire logic [7:0] p1_seg_sel,
  input wire logic [7:0] p3_com_sel,
  input wire logic [2:0] p0_seg_data,
  input wire logic [7:0] p1_seg_data,
  input wire logic [7:0] p3_com_data,
  // timers
  input wire logic tmr4_run,
  input wire logic tmr4_ext_clk_sel,
  input wire logic tmr4_clk_out_mode,
  input wire logic tmr4_clk_out,
  input wire logic [1:0] tmr2_mode,
  input wire logic tmr2_ext_event_en,
  input wire logic tmr2_downcount_en,
  input wire logic tmr2_run,
  input wire logic tmr2_counter_sel,
  input wire logic tmr2_clk_out_en,
  input wire logic tmr2_clk_out,
  input wire logic tmr3_run,
  input wire logic [1:0] tmr3_clk_sel,
  // interrupts
  input wire logic [3:0] ext_irq_en,
  input wire logic ext_irq_group_en,
  input wire logic [3:0] irq_line_sel,
  input wire logic [7:0] port0_drive_mode_reg,
  // serial
  input wire logic uart0_rx_en,
  input wire logic uart0_tx_write,
  input wire logic uart0_tx_release,
  input wire logic uart0_txd,
  input wire logic uart1_rx_en,
  input wire logic spi_enable_bit,
  input wire logic spi_master,
  input wire logic spi_phase_bit,
  input wire logic slave_select_disable,
  // analog and buzzer
  input wire logic [3:0] analog_chan_sel,
  input wire logic converter_on,
  input wire logic channel_select_field,
  input wire logic ext_reference_ctrl,
  input wire logic analog_chan8_sel,
  input wire logic buzzer_en,
  input wire logic buzzer_out,
  // option straps
  input wire logic [1:0] osc_pin_opt,
  input wire logic reset_pin_opt,
  // pads
  output logic [47:0] pad_oe,
  output logic [47:0] pad_do,
  output logic [47:0] pad_pu,
  output logic [47:0] pad_analog,
  // alternate-function ownership flags, set for any non-gpio owner
  output logic [47:0] pin_alt_owned
);
  typedef struct packed {
    logic tx0_own;
  } state_t;

  state_t st_reg;
  state_t st_next;
  owner_t owner [48];
  logic [47:0] alt_out;
  logic od45;

  // uart0 transmit takes the pin on a buffer write and holds it until a release
  always_comb begin
    st_next = st_reg;
    if (uart0_tx_write) begin
      st_next.tx0_own = 1'b1;
    end else if (uart0_tx_release) begin
      st_next.tx0_own = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '{tx0_own: TX0_OWN_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign od45 = (port0_drive_mode_reg == P0_OPEN_DRAIN_BOTH);

  // each pin walks its list top down; the first hit wins
  always_comb begin
    logic tmr2_capture_reload_in;
    logic ss_use;
    tmr2_capture_reload_in = 1'b0;
    ss_use = 1'b0;
    for (int i = 0; i < 48; i++) begin
      owner[i] = O_GPIO;
      alt_out[i] = 1'b0;
    end
    // port0 bit0..2
    if (pwm_unit_one_en && chan_b_out_en) begin
      owner[0] = O_OUT;
      alt_out[0] = pwm_comp_chan_b_out;
    end else if (!led_not_lcd_sel && p0_seg_sel[0]) begin
      owner[0] = O_DISP;
      alt_out[0] = p0_seg_data[0];
    end
    if (pwm_unit_zero_en && chan_b_out_en) begin
      owner[1] = O_OUT;
      alt_out[1] = pwm_zero_chan_b_out;
    end else if (!led_not_lcd_sel && p0_seg_sel[1]) begin
      owner[1] = O_DISP;
      alt_out[1] = p0_seg_data[1];
    end
    if (pwm_unit_zero_en && chan_a_out_en) begin
      owner[2] = O_OUT;
      alt_out[2] = pwm_comp_chan_a_out;
    end else if (!led_not_lcd_sel && p0_seg_sel[2]) begin
      owner[2] = O_DISP;
      alt_out[2] = p0_seg_data[2];
    end
    // port0 bit3
    if (pwm_unit_zero_en && chan_a_out_en) begin
      owner[3] = O_OUT;
      alt_out[3] = pwm_zero_chan_a_out;
    end else if (tmr4_run && tmr4_ext_clk_sel) begin
      owner[3] = O_IN_PU;
    end else if (tmr4_clk_out_mode) begin
      owner[3] = O_OUT;
      alt_out[3] = tmr4_clk_out;
    end
    // port0 bit4: mode 1 takes either enable, other modes only the external one
    if (tmr2_mode == 2'd1) begin
      tmr2_capture_reload_in = tmr2_downcount_en | tmr2_ext_event_en;
    end else begin
      tmr2_capture_reload_in = tmr2_ext_event_en;
    end
    if (tmr2_capture_reload_in) begin
      owner[4] = O_IN_PU;
    end else if (ext_irq_en[0] && !gpio_dir[4]) begin
      owner[4] = O_IN;
    end
    // port0 bit5
    if (tmr2_run && tmr2_counter_sel) begin
      owner[5] = O_IN_PU;
    end else if (!tmr2_counter_sel && tmr2_clk_out_en) begin
      owner[5] = O_OUT;
      alt_out[5] = tmr2_clk_out;
    end else if (ext_irq_en[1] && !gpio_dir[5]) begin
      owner[5] = O_IN;
    end
    // port0 bit6/7: crystal straps first
    if (osc_pin_opt[1]) begin
      owner[6] = O_OPT;
    end else if (ext_irq_en[2] && !gpio_dir[6]) begin
      owner[6] = O_IN;
    end
    if (osc_pin_opt[1]) begin
      owner[7] = O_OPT;
    end else if (ext_irq_en[3] && !gpio_dir[7]) begin
      owner[7] = O_IN;
    end
    // port1: irq group, then led over lcd
    for (int b = 0; b < 8; b++) begin
      if (b < 4 && ext_irq_group_en && irq_line_sel[b] && !gpio_dir[8+b]) begin
        owner[8+b] = O_IN;
      end else if (p1_seg_sel[b]) begin
        owner[8+b] = O_DISP;
        alt_out[8+b] = p1_seg_data[b];
      end
    end
    // port2
    if (uart0_rx_en) begin
      owner[16] = O_IN_PU;
    end
    if (st_reg.tx0_own) begin
      owner[17] = O_OUT;
      alt_out[17] = uart0_txd;
    end
    if (spi_enable_bit && !spi_master) begin
      owner[18] = (spi_phase_bit && slave_select_disable) ? O_IN_PU : O_IN;
    end else if (uart1_rx_en) begin
      owner[18] = O_IN_PU;
    end
    ss_use = spi_enable_bit &&
      ((spi_master && !slave_select_disable) ||
       (!spi_master && (!spi_phase_bit || !slave_select_disable)));
    if (fault_in_en) begin
      owner[21] = O_IN;
    end else if (ss_use) begin
      owner[21] = O_IN_PU;
    end
    // port3: analog on the upper half, commons below it
    for (int b = 0; b < 8; b++) begin
      if (b >= 4 && analog_chan_sel[b-4] && converter_on && channel_select_field) begin
        owner[24+b] = O_ANALOG;
      end else if (p3_com_sel[b] && display_duty) begin
        owner[24+b] = O_DISP;
        alt_out[24+b] = p3_com_data[b];
      end
    end
    // port4 bit4
    if (ext_reference_ctrl) begin
      owner[36] = O_ANALOG;
    end else if (analog_chan8_sel) begin
      owner[36] = O_ANALOG;
    end
    // port5 crystal and reset straps
    if (osc_pin_opt[0]) begin
      owner[40] = O_OPT;
      owner[41] = O_OPT;
    end
    if (reset_pin_opt) begin
      owner[42] = O_OPT;
    end
    // port5 bit3
    if (buzzer_en) begin
      owner[43] = O_OUT;
      alt_out[43] = buzzer_out;
    end else if (tmr3_run && tmr3_clk_sel == TMR3_EXT_CLK) begin
      owner[43] = O_IN_PU;
    end
  end

  // no register between decode and pad, so an enable acts within one cycle
  genvar g;
  generate
    for (g = 0; g < 48; g++) begin : pads
      pad_cell_ctrl u_pad (
        .owner(owner[g]),
        .alt_out(alt_out[g]),
        .open_drain(od45 && (g == P0_OD_LO || g == P0_OD_HI)),
        .gpio_dir(gpio_dir[g]),
        .gpio_pull(gpio_pull[g]),
        .gpio_data(gpio_data[g]),
        .pad_oe(pad_oe[g]),
        .pad_do(pad_do[g]),
        .pad_pu(pad_pu[g]),
        .pad_analog(pad_analog[g])
      );
      assign pin_alt_owned[g] = (owner[g] != O_GPIO);
    end
  endgenerate
endmodule

// ===== tb/pin_mux_chk.sv
`timescale 1ns/1ps
module pin_mux_chk
  import pin_mux_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // watched inputs
  input wire logic [47:0] gpio_dir,
  input wire logic [47:0] gpio_data,
  input wire logic pwm_unit_zero_en, pwm_unit_one_en, chan_a_out_en, chan_b_out_en,
  input wire logic pwm_comp_chan_b_out, pwm_zero_chan_b_out,
  input wire logic pwm_comp_chan_a_out, pwm_zero_chan_a_out,
  input wire logic led_not_lcd_sel,
  input wire logic [2:0] p0_seg_sel,
  input wire logic uart0_rx_en, uart0_tx_write, uart0_txd, buzzer_en, buzzer_out,
  input wire logic [7:0] port0_drive_mode_reg,
  input wire logic converter_on, channel_select_field, reset_pin_opt,
  input wire logic [3:0] analog_chan_sel,
  // pads
  input wire logic [47:0] pad_oe, pad_do, pad_pu, pad_analog, pin_alt_owned
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_gpio;
    !(pwm_unit_zero_en && chan_b_out_en) && !(!led_not_lcd_sel && p0_seg_sel[1])
      |-> pad_oe[1] == gpio_dir[1] && pad_do[1] == gpio_data[1];
  endproperty
  a_gpio: assert property (p_gpio) else $error("p0.1 not plain port");
  property p_pwm1b;
    pwm_unit_one_en && chan_b_out_en |-> pad_oe[0] && pad_do[0] == pwm_comp_chan_b_out;
  endproperty
  a_pwm1b: assert property (p_pwm1b) else $error("p0.0 pwm wrong");
  property p_pwm_zero_chan_b_out;
    pwm_unit_zero_en && chan_b_out_en |-> pad_oe[1] && pad_do[1] == pwm_zero_chan_b_out;
  endproperty
  a_pwm_zero_chan_b_out: assert property (p_pwm_zero_chan_b_out) else $error("p0.1 pwm wrong");
  property p_pwma;
    pwm_unit_zero_en && chan_a_out_en
      |-> pad_do[3:2] == {pwm_zero_chan_a_out, pwm_comp_chan_a_out} && pad_oe[3:2] == 2'h3;
  endproperty
  a_pwma: assert property (p_pwma) else $error("p0.2/3 pwm wrong");
  property p_od;
    port0_drive_mode_reg == P0_OPEN_DRAIN_BOTH && !pin_alt_owned[4] && gpio_data[4]
      |-> !pad_oe[4];
  endproperty
  a_od: assert property (p_od) else $error("p0.4 drives high");
  property p_rx0;
    uart0_rx_en |-> pad_pu[16] && !pad_oe[16] && pin_alt_owned[16];
  endproperty
  a_rx0: assert property (p_rx0) else $error("p2.0 not receive");
  property p_tx0;
    uart0_tx_write |=> pad_oe[17] && pad_do[17] == uart0_txd;
  endproperty
  a_tx0: assert property (p_tx0) else $error("p2.1 not taken");
  property p_adc;
    converter_on && channel_select_field && analog_chan_sel[0] |-> pad_analog[28];
  endproperty
  a_adc: assert property (p_adc) else $error("p3.4 not analog");
  property p_buz;
    buzzer_en |-> pad_oe[43] && pad_do[43] == buzzer_out;
  endproperty
  a_buz: assert property (p_buz) else $error("p5.3 not buzzer");
  property p_opt;
    reset_pin_opt |-> pin_alt_owned[42] && !pad_oe[42] && !pad_pu[42];
  endproperty
  a_opt: assert property (p_opt) else $error("p5.2 not reset pin");
endmodule

// ===== tb/port_function_priority_mux_tb_top.sv
`timescale 1ns/1ps
module port_function_priority_mux_tb_top
  import pin_mux_pkg::*;
;
  logic clk, resetn, pwm_unit_zero_en, pwm_unit_one_en, chan_a_out_en, chan_b_out_en;
  logic pwm_comp_chan_b_out, pwm_zero_chan_b_out, pwm_comp_chan_a_out, pwm_zero_chan_a_out;
  logic fault_in_en, led_not_lcd_sel, display_duty, tmr4_run, tmr4_ext_clk_sel;
  logic tmr4_clk_out_mode, tmr4_clk_out, tmr2_ext_event_en, tmr2_downcount_en, tmr2_run;
  logic tmr2_counter_sel, tmr2_clk_out_en, tmr2_clk_out, tmr3_run, ext_irq_group_en;
  logic uart0_rx_en, uart0_tx_write, uart0_tx_release, uart0_txd, uart1_rx_en;
  logic spi_enable_bit, spi_master, spi_phase_bit, slave_select_disable, converter_on;
  logic channel_select_field, ext_reference_ctrl, analog_chan8_sel, buzzer_en, buzzer_out;
  logic reset_pin_opt;
  logic [2:0] p0_seg_sel, p0_seg_data;
  logic [7:0] p1_seg_sel, p1_seg_data, p3_com_sel, p3_com_data, port0_drive_mode_reg;
  logic [1:0] tmr2_mode, tmr3_clk_sel, osc_pin_opt;
  logic [3:0] ext_irq_en, irq_line_sel, analog_chan_sel;
  logic [47:0] gpio_dir, gpio_pull, gpio_data, pad_oe, pad_do, pad_pu, pad_analog;
  logic [47:0] pin_alt_owned;
  int errors = 0;
  int check_count = 0;
  port_function_priority_mux u_dut (.*);
  always #50 clk = ~clk;
  task automatic ck(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: pad mismatch %h vs %h", $time, got, exp);
    end
  endtask
  // inputs move on the falling edge so every rising edge sees settled levels
  task automatic fall;
    @(negedge clk);
  endtask
  task automatic summarize;
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    summarize();
  end
  initial begin
    clk = 0;
    resetn = 0;
    {pwm_unit_zero_en, pwm_unit_one_en, chan_a_out_en, chan_b_out_en, pwm_comp_chan_b_out,
     pwm_zero_chan_b_out, pwm_comp_chan_a_out, pwm_zero_chan_a_out, fault_in_en,
     led_not_lcd_sel, display_duty, tmr4_run, tmr4_ext_clk_sel, tmr4_clk_out_mode,
     tmr4_clk_out, tmr2_ext_event_en, tmr2_downcount_en, tmr2_run, tmr2_counter_sel,
     tmr2_clk_out_en, tmr2_clk_out, tmr3_run, ext_irq_group_en, uart0_rx_en, uart0_tx_write,
     uart0_tx_release, uart0_txd, uart1_rx_en, spi_enable_bit, spi_master, spi_phase_bit,
     slave_select_disable, converter_on, channel_select_field, ext_reference_ctrl,
     analog_chan8_sel, buzzer_en, buzzer_out, reset_pin_opt} = '0;
    {p0_seg_sel, p0_seg_data, p1_seg_sel, p1_seg_data, p3_com_sel, p3_com_data} = '0;
    {port0_drive_mode_reg, tmr2_mode, tmr3_clk_sel, osc_pin_opt} = '0;
    {ext_irq_en, irq_line_sel, analog_chan_sel} = '0;
    gpio_dir = 48'h0000_00ff_00f0;
    gpio_pull = 48'h0f0f_0f0f_0f0f;
    gpio_data = 48'h00a5_5a00_3c3c;
    repeat (5) @(posedge clk);
    fall();
    resetn = 1;
    #20;
    ck(pad_oe, gpio_dir);
    ck(pad_do, gpio_data);
    ck(pad_pu, ~gpio_dir & gpio_pull);
    ck(pin_alt_owned, 48'h0);
    fall();
    p0_seg_sel = 3'h1;
    {pwm_unit_one_en, chan_b_out_en, pwm_comp_chan_b_out} = 3'h7;
    #20;
    ck({pad_oe[0], pad_do[0]}, 2'h3);
    fall();
    gpio_data[0] = 1;
    pwm_comp_chan_b_out = 0;
    #20;
    ck(pad_do[0], 1'b0);
    fall();
    pwm_unit_one_en = 0;
    #20;
    ck(pin_alt_owned[0], 1'b1);
    fall();
    p0_seg_sel = 0;
    {pwm_unit_zero_en, chan_a_out_en, pwm_zero_chan_a_out, pwm_zero_chan_b_out} = 4'hf;
    {tmr4_run, tmr4_ext_clk_sel} = 2'h3;
    #20;
    ck(pad_do[3:1], 3'h5);
    ck({pad_oe[3:1], pad_pu[3]}, 4'he);
    fall();
    {pwm_unit_zero_en, chan_a_out_en, chan_b_out_en} = 0;
    {tmr2_run, tmr2_counter_sel, tmr2_ext_event_en, uart0_rx_en, uart1_rx_en} = 5'h1f;
    ext_irq_en = 4'hf;
    gpio_dir[7:4] = 0;
    {ext_irq_group_en, irq_line_sel} = 5'h11;
    #20;
    ck({pad_pu[3], pad_oe[3]}, 2'h2);
    ck(pad_pu[5:4], 2'h3);
    ck({pad_pu[16], pad_oe[16], pad_pu[18], pad_oe[18]}, 4'ha);
    ck(pin_alt_owned[9:6], 4'h7);
    fall();
    {tmr2_run, tmr2_ext_event_en} = 0;
    #20;
    ck(pin_alt_owned[5:4], 2'h3);
    fall();
    ext_irq_en = 0;
    gpio_dir[5:4] = 2'h3;
    gpio_data[5:4] = 2'h1;
    port0_drive_mode_reg = P0_OPEN_DRAIN_BOTH;
    #20;
    ck(pad_oe[5:4], 2'h2);
    fall();
    port0_drive_mode_reg = 8'h10;
    gpio_dir[17] = 0;
    {uart0_tx_write, uart0_txd} = 2'h3;
    #20;
    ck(pad_oe[5:4], 2'h3);
    ck(pad_oe[17], 1'b0);
    fall();
    {uart0_tx_write, uart0_tx_release} = 2'h3;
    #20;
    ck({pad_oe[17], pad_do[17]}, 2'h3);
    fall();
    {uart0_tx_write, uart0_tx_release} = 0;
    #20;
    ck(pin_alt_owned[17], 1'b1);
    fall();
    uart0_tx_release = 1;
    fall();
    uart0_tx_release = 0;
    uart0_tx_write = 1;
    #20;
    ck(pin_alt_owned[17], 1'b0);
    fall();
    uart0_tx_write = 0;
    resetn = 0;
    #20;
    ck(pad_oe[17], 1'b0);
    fall();
    resetn = 1;
    {spi_enable_bit, spi_master} = 2'h3;
    {converter_on, channel_select_field, ext_reference_ctrl} = 3'h7;
    analog_chan_sel = 4'h9;
    {p3_com_sel, display_duty, led_not_lcd_sel} = {8'h11, 2'h3};
    {tmr3_run, tmr3_clk_sel} = {1'b1, TMR3_EXT_CLK};
    #20;
    ck({pin_alt_owned[21], pad_oe[21]}, 2'h2);
    ck({pad_analog[31:28], pad_analog[36]}, 5'h13);
    ck(pin_alt_owned[24], 1'b1);
    ck({pad_pu[43], pad_oe[43]}, 2'h2);
    fall();
    {fault_in_en, buzzer_en, buzzer_out, reset_pin_opt, osc_pin_opt} = 6'h3f;
    #20;
    ck({pin_alt_owned[21], pad_oe[21]}, 2'h2);
    ck({pad_oe[43], pad_do[43]}, 2'h3);
    ck({pin_alt_owned[42:40], pin_alt_owned[7:6]}, 5'h1f);
    fall();
    // spi slave with phase and ss disable: data-in pull-up, no slave select
    {fault_in_en, spi_master, spi_phase_bit, slave_select_disable} = 4'h3;
    // timer-2 mode 1 takes p0.4 on down-count enable alone
    tmr2_mode = 2'h1;
    tmr2_downcount_en = 1;
    {tmr2_counter_sel, tmr2_clk_out_en, tmr2_clk_out} = 3'h3;
    {tmr4_run, tmr4_clk_out_mode, tmr4_clk_out} = 3'h3;
    {p1_seg_sel, p1_seg_data} = {8'h80, 8'h80};
    {ext_reference_ctrl, analog_chan8_sel} = 2'h1;
    #20;
    ck({pad_pu[18], pin_alt_owned[21]}, 2'h2);
    ck({pad_pu[4], pad_oe[4]}, 2'h2);
    ck({pad_oe[5], pad_do[5], pad_oe[3], pad_do[3]}, 4'hf);
    ck({pad_oe[15], pad_do[15], pad_analog[36]}, 3'h7);
    summarize();
  end
endmodule
bind port_function_priority_mux pin_mux_chk u_chk (.*);
